// ===== core/rsc_top.sv
// Purpose: reset source controller, six sources into one device reset
// Assumes: rst is the power-on detector output; key_open is high
//   while the protection window for the io register key is open
// Notes: fuse fields are static while running
// How it works
// - enabled low reset pin holds reset
// - watchdog time-out issues system reset
// - writing trigger bit starts reset two clocks later
// - trigger bit always reads zero
// - all but power-on reload fuses; supply resets debug
// - active phase, then init after release
// - supply resets add start-up fuse time
// - crc start-up scan lengthens init phase
// - runs in active and all sleep modes
// - unlocked-less protected writes are ignored
// - trigger register needs io register key
// - each reset type sets its flag
// - write one clears flag, zero keeps
// - power-on leaves only power-on flag
// - no other flags until boot completes
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module rsc_top
  import rsc_pkg::*;
#(
  parameter int SUT_UNIT_CYC = rsc_pkg::SUT_UNIT_CYC_DEF,
  parameter int CRC_SCAN_CYC = rsc_pkg::CRC_SCAN_CYC_DEF
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [rsc_pkg::ADDR_W-1:0] addr,
  input wire logic [rsc_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [rsc_pkg::DATA_W-1:0] rd_data,
  // protection window
  input wire logic key_open,
  // reset sources
  input wire logic reset_pin_n,
  input wire logic bod_det,
  input wire logic wdt_timeout,
  input wire logic dbg_reset_req,
  // fuses
  input wire logic [1:0] reset_pin_fuse_field,
  input wire logic [2:0] startup_time_field,
  input wire logic [1:0] crc_source_field,
  // reset outputs
  output logic sys_rst,
  output logic dbg_rst,
  output logic fuse_reload
);
  import rsc_pkg::*;

  // ==========================================================
  // source conditioning
  logic [1:0] async_s;
  logic pin_low;
  logic bod_s;
  logic pin_req;
  logic sw_pend;
  logic any_req;
  logic [NFLAG-1:0] set_vec;

  rsc_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({bod_det, ~reset_pin_n}),
    .q(async_s)
  );

  assign pin_low = async_s[0];
  assign bod_s = async_s[1];
  assign pin_req = pin_low && (reset_pin_fuse_field == PIN_CFG_RESET);
  // debug request only ever comes from the debug port pin side
  assign any_req = pin_req || bod_s || wdt_timeout || sw_pend
                   || dbg_reset_req;

  // ==========================================================
  // register decode
  logic wr_flags;
  logic wr_trig;
  logic rd_flags;
  logic sw_fire;

  assign wr_flags = wr_en && (addr == OFF_FLAGS);
  assign wr_trig = wr_en && (addr == OFF_TRIG);
  assign rd_flags = rd_en && (addr == OFF_FLAGS);
  // key-less writes fall through with no effect
  assign sw_fire = wr_trig && key_open && wr_data[TRIG_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_pend <= 1'b0;
    end else begin
      sw_pend <= sw_fire;
    end
  end

  // ==========================================================
  // sequencer
  // clock never gated by sleep state, so sources act in every mode
  rsc_state_t state;
  rsc_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] sut_cyc;
  logic [31:0] init_len;
  logic crc_on;
  logic ps_cause;
  logic next_ps_cause;
  logic init_done;
  logic boot_pend;

  assign sut_cyc = (startup_time_field == 3'h0) ? 32'h0 :
    (32'(SUT_UNIT_CYC) << (startup_time_field - 3'h1));
  assign crc_on = (crc_source_field != CRC_SRC_NONE);
  assign init_len = INIT_BASE_CYC
                    + (ps_cause ? sut_cyc : 32'h0)
                    + (crc_on ? 32'(CRC_SCAN_CYC) : 32'h0);
  assign init_done = (state == ST_INIT) && (cnt >= init_len - 32'h1);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ps_cause = ps_cause || bod_s;
    unique case (state)
      ST_RUN: begin
        next_ps_cause = bod_s;
        if (any_req) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        next_cnt = 32'h0;
        if (!any_req) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        next_cnt = cnt + 32'h1;
        if (any_req) begin
          next_state = ST_ACTIVE;
        end else if (init_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_INIT;
      cnt <= 32'h0;
      ps_cause <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ps_cause <= next_ps_cause;
    end
  end

  // ==========================================================
  // reset outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_rst <= 1'b1;
      dbg_rst <= 1'b1;
      fuse_reload <= 1'b0;
      boot_pend <= 1'b1;
    end else begin
      sys_rst <= (next_state != ST_RUN);
      dbg_rst <= (next_state != ST_RUN) && next_ps_cause;
      fuse_reload <= (state == ST_ACTIVE) && !any_req;
      if (init_done && !any_req) begin
        boot_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // cause flags
  logic [NFLAG-1:0] flags;

  assign set_vec[F_POR] = 1'b0;
  assign set_vec[F_BOR] = bod_s;
  assign set_vec[F_PIN] = pin_req;
  assign set_vec[F_WDT] = wdt_timeout;
  assign set_vec[F_SW] = sw_pend;
  assign set_vec[F_DBG] = dbg_reset_req;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RST;
    end else if (!boot_pend) begin
      // set beats a same-cycle clear
      flags <= (flags & ~(wr_flags ? wr_data[NFLAG-1:0] : '0))
               | set_vec;
    end else begin
      flags <= flags & ~(wr_flags ? wr_data[NFLAG-1:0] : '0);
    end
  end

  // ==========================================================
  // read port, trigger register and unmapped read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_flags) begin
      rd_data <= {2'h0, flags};
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  AST_PIN: assert property (@(posedge clk) disable iff (rst)
    pin_req |=> sys_rst)
    else $error("pin low did not hold reset");
  AST_WDT: assert property (@(posedge clk) disable iff (rst)
    wdt_timeout |=> sys_rst ##1 state == ST_INIT)
    else $error("watchdog time-out gave no reset");
  AST_SWR: assert property (@(posedge clk) disable iff (rst)
    sw_fire |-> ##2 sys_rst)
    else $error("software trigger gave no reset");
  AST_SWRD: assert property (@(posedge clk) disable iff (rst)
    rd_en && addr == OFF_TRIG |=> rd_data == 8'h00)
    else $error("trigger register read nonzero");
  AST_DBG: assert property (@(posedge clk) disable iff (rst)
    state == ST_RUN && wdt_timeout && !bod_s |=> sys_rst && !dbg_rst)
    else $error("user reset touched debug logic");
  AST_FUSE: assert property (@(posedge clk) disable iff (rst)
    state == ST_ACTIVE && !any_req |=> fuse_reload && state == ST_INIT)
    else $error("no fuse reload at init start");
  AST_ACT: assert property (@(posedge clk) disable iff (rst)
    any_req |=> state == ST_ACTIVE)
    else $error("request did not enter active phase");
  AST_SUT: assert property (@(posedge clk) disable iff (rst)
    !ps_cause && !crc_on |-> init_len == INIT_BASE_CYC)
    else $error("start-up time added to user reset");
  AST_CRC: assert property (@(posedge clk) disable iff (rst)
    crc_on && !ps_cause |-> init_len == INIT_BASE_CYC + 32'(CRC_SCAN_CYC))
    else $error("crc scan time missing");
  AST_LOCK: assert property (@(posedge clk) disable iff (rst)
    wr_trig && !key_open |=> !sw_pend)
    else $error("locked trigger write acted");
  AST_SET: assert property (@(posedge clk) disable iff (rst)
    !boot_pend && wdt_timeout |=> flags[F_WDT])
    else $error("watchdog flag not set");
  AST_CLR: assert property (@(posedge clk) disable iff (rst)
    wr_flags && wr_data[F_PIN] && !set_vec[F_PIN] |=> !flags[F_PIN])
    else $error("flag not cleared by write one");
  AST_BOOT: assert property (@(posedge clk) disable iff (rst)
    boot_pend && flags[5:1] == 5'h0 |=> flags[5:1] == 5'h0)
    else $error("flag set before boot completed");
  AST_REL: assert property (@(posedge clk) disable iff (rst)
    init_done && !any_req |=> !sys_rst && state == ST_RUN)
    else $error("reset not released after init");

  COV_SW: cover property (@(posedge clk) disable iff (rst)
    sw_fire ##2 sys_rst);
  COV_PIN: cover property (@(posedge clk) disable iff (rst)
    pin_req ##1 !pin_req);
  COV_BOD: cover property (@(posedge clk) disable iff (rst)
    state == ST_RUN && bod_s ##1 dbg_rst);
  COV_REL: cover property (@(posedge clk) disable iff (rst)
    $fell(sys_rst));
endmodule : rsc_top

// ===== core/rsc_pkg.sv
// Purpose: shared constants and types of the reset source controller
// Assumes: 20 MHz clock, register port with 4-bit address, 8-bit data
// Notes: fuse field encodings are fixed here
package rsc_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_TRIG = 4'h1;
  localparam int TRIG_BIT = 0;
  // cause flag positions
  localparam int F_POR = 0;
  localparam int F_BOR = 1;
  localparam int F_PIN = 2;
  localparam int F_WDT = 3;
  localparam int F_SW = 4;
  localparam int F_DBG = 5;
  localparam int NFLAG = 6;
  localparam logic [5:0] FLAGS_RST = 6'h01;
  // ==========================================================
  // fuse encodings
  localparam logic [1:0] PIN_CFG_RESET = 2'h2;
  localparam logic [1:0] CRC_SRC_NONE = 2'h3;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INIT_BASE_NS = 800;
  localparam logic [31:0] INIT_BASE_CYC =
    32'((INIT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SUT_UNIT_MS = 1;
  localparam int SUT_UNIT_CYC_DEF = SUT_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CRC_SCAN_CYC_DEF = 8192;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_INIT = 2'b10
  } rsc_state_t;
endpackage : rsc_pkg

// ===== core/rsc_sync.sv
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: inputs are quasi-static levels
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
module rsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // two stages
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rsc_sync

// ===== bench/rsc_partner.sv
// Purpose: far-side model of the reset pin and the debugger
// Assumes: bench commands are levels on the bench clock
// Notes: the pin has a pull-up, so it idles high
`timescale 1ns/1ns
module rsc_partner (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic pin_cmd,
  input wire logic dbg_cmd,
  // lines into the block
  output logic reset_pin_n,
  output logic dbg_reset_req
);
  // ==========================================================
  // drivers
  initial begin
    reset_pin_n = 1'b1;
    dbg_reset_req = 1'b0;
  end
  always @(posedge clk) begin
    reset_pin_n <= ~pin_cmd;
    dbg_reset_req <= dbg_cmd;
  end
endmodule : rsc_partner

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the reset source controller
// Assumes: start-up unit 4 cycles, start-up field 1, crc scan 8 cycles, on only in the crc test
// Notes: init lengths are checked as windows or lower bounds from the base count
`timescale 1ns/1ns
module tb_top;
  import rsc_pkg::*;
  localparam int STARTUP_TIME_FIELD = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic key_open = 1'b0;
  logic [1:0] crc_src = CRC_SRC_NONE;
  logic bod_det = 1'b0;
  logic wdt_timeout = 1'b0;
  logic pin_cmd = 1'b0;
  logic dbg_cmd = 1'b0;
  logic reset_pin_n, dbg_reset_req, sys_rst, dbg_rst, fuse_reload;
  logic [7:0] v;
  logic dr, fr;
  int hi;
  int fails = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  rsc_partner i_rsc_partner (.clk(clk), .pin_cmd(pin_cmd),
    .dbg_cmd(dbg_cmd), .reset_pin_n(reset_pin_n),
    .dbg_reset_req(dbg_reset_req));
  rsc_top #(.SUT_UNIT_CYC(STARTUP_TIME_FIELD), .CRC_SCAN_CYC(8)) i_rsc_top (.clk(clk),
    .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .key_open(key_open),
    .reset_pin_n(reset_pin_n), .bod_det(bod_det),
    .wdt_timeout(wdt_timeout), .dbg_reset_req(dbg_reset_req),
    .reset_pin_fuse_field(PIN_CFG_RESET), .startup_time_field(3'h1),
    .crc_source_field(crc_src), .sys_rst(sys_rst),
    .dbg_rst(dbg_rst), .fuse_reload(fuse_reload));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic u);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    key_open <= u;
    @(posedge clk);
    wr_en <= 1'b0;
    key_open <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  // waits for sys_rst, then counts its high cycles
  task automatic run_reset();
    int n;
    n = 0;
    hi = 0;
    dr = 1'b0;
    fr = 1'b0;
    while (sys_rst !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    while (sys_rst === 1'b1 && hi < 400) begin
      dr = dr | dbg_rst;
      fr = fr | fuse_reload;
      @(posedge clk);
      #1 hi++;
    end
  endtask : run_reset
  // source select: 0 watchdog, 1 pin, 2 debugger, 3 brown-out
  task automatic drv(input int k, input logic b);
    case (k)
      0: wdt_timeout <= b;
      1: pin_cmd <= b;
      2: dbg_cmd <= b;
      default: bod_det <= b;
    endcase
  endtask : drv
  task automatic pulse(input int k, input int n);
    @(posedge clk);
    drv(k, 1'b1);
    repeat (n) @(posedge clk);
    drv(k, 1'b0);
  endtask : pulse
  // ==========================================================
  // scenarios
  task automatic t_boot();
    pulse(0, 1);
    run_reset();
    chk("boot dbg", dr, 1);
    chk("boot len", hi >= INIT_BASE_CYC / 2, 1);
    rd(OFF_FLAGS, v);
    chk("por flags", v, FLAGS_RST);
    wr(OFF_FLAGS, 8'h3f, 1'b0);
    rd(OFF_FLAGS, v);
    chk("clear", v, 8'h00);
  endtask : t_boot
  task automatic t_soft();
    wr(OFF_TRIG, 8'h01, 1'b0);
    repeat (6) @(posedge clk);
    chk("locked", sys_rst, 0);
    rd(OFF_TRIG, v);
    chk("trig rd", v, 8'h00);
    rd(4'hf, v);
    chk("unmapped", v, 8'h00);
    wr(OFF_TRIG, 8'h01, 1'b1);
    run_reset();
    chk("sw len", hi >= 16 && hi <= 18, 1);
    chk("sw reload", fr, 1);
    chk("sw dbg", dr, 0);
    wr(OFF_FLAGS, 8'h00, 1'b0);
    rd(OFF_FLAGS, v);
    chk("sw flag", v, 8'h10);
  endtask : t_soft
  task automatic t_wdt();
    wr(OFF_FLAGS, 8'h3f, 1'b0);
    pulse(0, 1);
    run_reset();
    chk("wdt len", hi >= 16 && hi <= 18, 1);
    rd(OFF_FLAGS, v);
    chk("wdt flag", v, 8'h08);
  endtask : t_wdt
  task automatic t_pin();
    wr(OFF_FLAGS, 8'h3f, 1'b0);
    pulse(1, 30);
    chk("pin held", sys_rst, 1);
    run_reset();
    chk("pin init", hi >= 16, 1);
    rd(OFF_FLAGS, v);
    chk("pin flag", v, 8'h04);
  endtask : t_pin
  task automatic t_dbg();
    wr(OFF_FLAGS, 8'h3f, 1'b0);
    pulse(2, 5);
    run_reset();
    chk("dbg keep", dr, 0);
    rd(OFF_FLAGS, v);
    chk("dbg flag", v, 8'h20);
  endtask : t_dbg
  task automatic t_bod();
    wr(OFF_FLAGS, 8'h3f, 1'b0);
    pulse(3, 5);
    run_reset();
    chk("bod dbg", dr, 1);
    chk("bod len", hi >= 16 + STARTUP_TIME_FIELD, 1);
    rd(OFF_FLAGS, v);
    chk("bod flag", v, 8'h02);
  endtask : t_bod
  // crc scan at start-up adds its 8 cycles to a user reset
  task automatic t_crc();
    @(posedge clk);
    crc_src <= 2'h0;
    wr(OFF_TRIG, 8'h01, 1'b1);
    run_reset();
    chk("crc len", hi >= 24 && hi <= 26, 1);
    chk("crc dbg", dr, 0);
    @(posedge clk);
    crc_src <= CRC_SRC_NONE;
  endtask : t_crc
  // ==========================================================
  // verdict and sequence
  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #(50 * 4000);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_soft();
    t_wdt();
    t_pin();
    t_dbg();
    t_bod();
    t_crc();
    print_verdict();
  end
endmodule : tb_top
